/* File: asc_converter.sv */
`default_nettype none
// Functional notes
// - conversion ignores channel and direction bits
// - analog pins read zero on ports A, E
// - analog pins read one on port B
// - digital-input pins still convert when selected
// - reference field selects high and low references
// - external reference pin forced analog
// - go starts thirteen-period conversion
// - done clears go, sets interrupt flag
// - clearing go aborts conversion immediately
// - abort writes partial result
// - power-on with go in one write cancels
// - results not reset by reset
module asc_converter (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // register port
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // pins
    input wire logic [7:0] port_a_pins_i,
    input wire logic [7:0] port_b_pins_i,
    input wire logic [7:0] port_e_pins_i,
    // analog front end: sampled comparator decision per bit
    input wire logic cmp_i,
    output logic [2:0] ref_high_sel_o,
    output logic [1:0] ref_low_sel_o,
    output logic [7:0] analog_en_o,
    output logic sample_o,
    // interrupt
    output logic irq_o
);
    typedef enum {ASC_IDLE, ASC_CONV} asc_state_e;

    logic [7:0] ctl_r, ctl_nxt;
    logic [7:0] cfg_r, cfg_nxt;
    logic [7:0] dir_r, dir_nxt;
    logic [11:0] res_r, res_nxt;
    logic [11:0] sar_r, sar_nxt;
    logic [3:0] per_r, per_nxt;
    logic sts_r, sts_nxt;
    logic ien_r, ien_nxt;
    logic cmp_m_r, cmp_r;
    logic [7:0] pa_m_r, pa_r, pb_m_r, pb_r, pe_m_r, pe_r;
    logic [7:0] rdata_nxt;
    logic irq_nxt;
    logic [2:0] rh_nxt;
    logic [1:0] rl_nxt;
    logic [7:0] analog;
    logic tick;
    logic done_ev;
    logic [7:0] an_nxt;
    logic sample_nxt;
    asc_state_e st_r, st_nxt;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
        hit = (a == o);
    endfunction

    asc_period_gen u_period (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .run_i(st_r == ASC_CONV),
        .clk_sel_i(ctl_r[asc_pkg::CTL_CLK_LSB +: 2]),
        .tick_o(tick)
    );

    asc_pin_map u_map (
        .map_i(cfg_r[asc_pkg::CFG_MAP_LSB +: 4]),
        .ref_sel_i(cfg_r[asc_pkg::CFG_REF_LSB +: 2]),
        .analog_o(analog)
    );

    // pin and comparator inputs are asynchronous
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {cmp_m_r, cmp_r} <= 2'h0;
            {pa_m_r, pa_r, pb_m_r, pb_r, pe_m_r, pe_r} <= '0;
        end else begin
            cmp_m_r <= cmp_i;
            cmp_r <= cmp_m_r;
            pa_m_r <= port_a_pins_i;
            pa_r <= pa_m_r;
            pb_m_r <= port_b_pins_i;
            pb_r <= pb_m_r;
            pe_m_r <= port_e_pins_i;
            pe_r <= pe_m_r;
        end
    end

    // conversion sequence; channel and direction never gate it
    always_comb begin
        ctl_nxt = ctl_r;
        st_nxt = st_r;
        per_nxt = per_r;
        sar_nxt = sar_r;
        res_nxt = res_r;
        done_ev = 1'b0;
        if (wr_i && hit(addr_i, asc_pkg::ADDR_CONTROL)) begin
            ctl_nxt = wdata_i;
            // go bit is not stored when power is turned on in the same write
            if (wdata_i[asc_pkg::CTL_POWER_BIT] &&
                !ctl_r[asc_pkg::CTL_POWER_BIT]) begin
                ctl_nxt[asc_pkg::CTL_GO_BIT] = 1'b0;
            end
            if (!wdata_i[asc_pkg::CTL_POWER_BIT]) begin
                ctl_nxt[asc_pkg::CTL_GO_BIT] = 1'b0;
            end
        end
        case (st_r)
            ASC_IDLE: begin
                if (ctl_nxt[asc_pkg::CTL_GO_BIT]) begin
                    st_nxt = ASC_CONV;
                    per_nxt = 4'h0;
                    sar_nxt = 12'h800;
                end
            end
            ASC_CONV: begin
                if (!ctl_nxt[asc_pkg::CTL_GO_BIT]) begin
                    st_nxt = ASC_IDLE;
                    res_nxt = sar_r;
                end else if (tick) begin
                    per_nxt = per_r + 4'h1;
                    // periods 1..12 resolve one bit each, msb first
                    if (per_r >= 4'h1 && per_r <= 4'hc) begin
                        sar_nxt[4'hc - per_r] = cmp_r;
                        if (per_r != 4'hc) begin
                            sar_nxt[4'hb - per_r] = 1'b1;
                        end
                    end
                    if (per_r == asc_pkg::CONV_PERIODS - 4'h1) begin
                        st_nxt = ASC_IDLE;
                        ctl_nxt[asc_pkg::CTL_GO_BIT] = 1'b0;
                        // the last decision lands together with the result
                        res_nxt = sar_nxt;
                        done_ev = 1'b1;
                    end
                end
            end
            default: st_nxt = ASC_IDLE;
        endcase
    end

    // result registers hold through reset
    always_ff @(posedge sys_clk_i) begin
        res_r <= res_nxt;
    end

    // interrupt status, enable, clear; set wins over clear
    always_comb begin
        sts_nxt = sts_r;
        ien_nxt = ien_r;
        if (wr_i && hit(addr_i, asc_pkg::ADDR_IRQ_CLEAR) && wdata_i[0]) begin
            sts_nxt = 1'b0;
        end
        if (done_ev) begin
            sts_nxt = 1'b1;
        end
        if (wr_i && hit(addr_i, asc_pkg::ADDR_IRQ_ENABLE)) begin
            ien_nxt = wdata_i[0];
        end
        irq_nxt = sts_nxt & ien_nxt;
    end

    // configuration registers and outputs
    always_comb begin
        cfg_nxt = cfg_r;
        dir_nxt = dir_r;
        if (wr_i && hit(addr_i, asc_pkg::ADDR_PIN_REF_CONFIG)) begin
            cfg_nxt = wdata_i;
        end
        if (wr_i && hit(addr_i, asc_pkg::ADDR_PIN_DIRECTION)) begin
            dir_nxt = wdata_i;
        end
        // ref bit0: external +, bit1: external -, bit2: internal high
        case (cfg_r[asc_pkg::CFG_REF_LSB +: 3])
            3'h0, 3'h2: rh_nxt = 3'h3; // analog supply
            3'h4, 3'h6: rh_nxt = 3'h0; // internal high
            3'h1, 3'h3, 3'h5, 3'h7: rh_nxt = 3'h2; // external pin
            default: rh_nxt = 3'h1; // internal low
        endcase
        if (cfg_r[asc_pkg::CFG_REF_LSB + 3]) begin
            rh_nxt = 3'h1;
        end
        if (cfg_r[asc_pkg::CFG_REF_LSB + 1]) begin
            rl_nxt = 2'h1;
        end else if (cfg_r[asc_pkg::CFG_REF_LSB + 2]) begin
            rl_nxt = 2'h0;
        end else begin
            rl_nxt = 2'h2;
        end
        an_nxt = analog;
        sample_nxt = (st_nxt == ASC_CONV) && (per_nxt == 4'h0);
    end

    // read mux; data stand in the cycle after the strobe
    always_comb begin
        rdata_nxt = 8'h00;
        if (rd_i) begin
            case (addr_i)
                asc_pkg::ADDR_CONTROL: rdata_nxt = ctl_r;
                asc_pkg::ADDR_PIN_REF_CONFIG: rdata_nxt = cfg_r;
                asc_pkg::ADDR_RESULT_HIGH: rdata_nxt = {4'h0, res_r[11:8]};
                asc_pkg::ADDR_RESULT_LOW: rdata_nxt = res_r[7:0];
                asc_pkg::ADDR_IRQ_STATUS: rdata_nxt = {7'h00, sts_r};
                asc_pkg::ADDR_IRQ_ENABLE: rdata_nxt = {7'h00, ien_r};
                asc_pkg::ADDR_PORT_A: rdata_nxt = pa_r & ~analog;
                asc_pkg::ADDR_PORT_B: rdata_nxt = pb_r | analog;
                asc_pkg::ADDR_PORT_E: rdata_nxt = pe_r & ~analog;
                asc_pkg::ADDR_PIN_DIRECTION: rdata_nxt = dir_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctl_r <= asc_pkg::CONTROL_RESET;
            cfg_r <= asc_pkg::PIN_REF_RESET;
            dir_r <= asc_pkg::DIRECTION_RESET;
            st_r <= ASC_IDLE;
            per_r <= 4'h0;
            sar_r <= 12'h000;
            sts_r <= 1'b0;
            ien_r <= 1'b0;
            irq_o <= 1'b0;
            rdata_o <= 8'h00;
            ref_high_sel_o <= 3'h3;
            ref_low_sel_o <= 2'h2;
            analog_en_o <= 8'h00;
            sample_o <= 1'b0;
        end else begin
            ctl_r <= ctl_nxt;
            cfg_r <= cfg_nxt;
            dir_r <= dir_nxt;
            st_r <= st_nxt;
            per_r <= per_nxt;
            sar_r <= sar_nxt;
            sts_r <= sts_nxt;
            ien_r <= ien_nxt;
            irq_o <= irq_nxt;
            rdata_o <= rdata_nxt;
            ref_high_sel_o <= rh_nxt;
            ref_low_sel_o <= rl_nxt;
            analog_en_o <= an_nxt;
            sample_o <= sample_nxt;
        end
    end

    // checks
    a_done_sets_flag: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i) done_ev |=> sts_r && !ctl_r[2])
        else $error("completion did not set flag and clear go");
    a_abort_idle: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (st_r == ASC_CONV && wr_i && addr_i == 4'h0 && !wdata_i[2])
        |=> st_r == ASC_IDLE && res_r == $past(sar_r))
        else $error("abort did not stop and store partial result");
    a_power_go: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (wr_i && addr_i == 4'h0 && wdata_i[0] && !ctl_r[0])
        |=> !ctl_r[2] && st_r == ASC_IDLE)
        else $error("power-on with go started a conversion");
    a_port_b_one: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i) (rd_i && addr_i == 4'h8)
        |=> (rdata_o & $past(analog)) == $past(analog))
        else $error("analog pin on port B not read as one");
    a_port_a_zero: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i) (rd_i && addr_i == 4'h7)
        |=> (rdata_o & $past(analog)) == 8'h00)
        else $error("analog pin on port A not read as zero");
    a_result_load: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i) done_ev |=> res_r == sar_r)
        else $error("result not loaded on completion");
    a_ext_ref_pin: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i) cfg_r[4] |-> analog[3])
        else $error("external reference pin not analog");
    a_irq_level: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i) (sts_r && ien_r) |-> irq_o)
        else $error("enabled flag without interrupt");
    a_conv_start: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (st_r == ASC_IDLE && ctl_nxt[2]) |=> st_r == ASC_CONV)
        else $error("go did not start conversion");
    c_complete: cover property (@(posedge sys_clk_i) done_ev);
    c_abort: cover property (@(posedge sys_clk_i)
        st_r == ASC_CONV ##1 st_r == ASC_IDLE && !sts_r);
    c_irq: cover property (@(posedge sys_clk_i) irq_o);
endmodule
`default_nettype wire

/* File: asc_pkg.sv */
`default_nettype none
package asc_pkg;
    // register map
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_PIN_REF_CONFIG = 4'h1;
    localparam logic [3:0] ADDR_RESULT_HIGH = 4'h2;
    localparam logic [3:0] ADDR_RESULT_LOW = 4'h3;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h5;
    localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h6;
    localparam logic [3:0] ADDR_PORT_A = 4'h7;
    localparam logic [3:0] ADDR_PORT_B = 4'h8;
    localparam logic [3:0] ADDR_PORT_E = 4'h9;
    localparam logic [3:0] ADDR_PIN_DIRECTION = 4'ha;
    // converter_control fields
    localparam int CTL_POWER_BIT = 0;
    localparam int CTL_GO_BIT = 2;
    localparam int CTL_CHAN_LSB = 3;
    localparam int CTL_CLK_LSB = 6;
    // converter_pin_ref_config fields
    localparam int CFG_MAP_LSB = 0;
    localparam int CFG_REF_LSB = 4;
    // reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] PIN_REF_RESET = 8'h00;
    localparam logic [7:0] DIRECTION_RESET = 8'hff;
    // timing in conversion-clock periods
    localparam logic [3:0] ACQ_PERIODS = 4'h3;
    localparam logic [3:0] CONV_PERIODS = 4'hd;
    localparam int RESULT_BITS = 12;
    // external reference pins in the analog channel map
    localparam int VREF_POS_CH = 3;
    localparam int VREF_NEG_CH = 2;
endpackage
`default_nettype wire

/* File: asc_tad_gen.sv */
`default_nettype none
// conversion-clock tick from the core clock, divide by 2,8,32 or 64
module asc_period_gen (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic run_i,
    input wire logic [1:0] clk_sel_i,
    // tick
    output logic tick_o
);
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;
    logic [5:0] last;
    logic tick_nxt;

    always_comb begin
        case (clk_sel_i)
            2'h0: last = 6'h01;
            2'h1: last = 6'h07;
            2'h2: last = 6'h1f;
            default: last = 6'h3f;
        endcase
        tick_nxt = 1'b0;
        cnt_nxt = cnt_r + 6'h01;
        // restarting keeps every period whole from the first one
        if (!run_i) begin
            cnt_nxt = 6'h00;
        end else if (cnt_r >= last) begin
            cnt_nxt = 6'h00;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= 6'h00;
            tick_o <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_o <= tick_nxt;
        end
    end
endmodule
`default_nettype wire

/* File: asc_pin_map.sv */
`default_nettype none
// analog channel assignment per pin, external references forced analog
module asc_pin_map (
    input wire logic [3:0] map_i,
    input wire logic [1:0] ref_sel_i,
    output logic [7:0] analog_o
);
    always_comb begin
        // higher map codes give fewer analog channels
        analog_o = 8'hff >> map_i[2:0];
        if (map_i[3]) begin
            analog_o = 8'h00;
        end
        if (ref_sel_i[0]) begin
            analog_o[asc_pkg::VREF_POS_CH] = 1'b1;
        end
        if (ref_sel_i[1]) begin
            analog_o[asc_pkg::VREF_NEG_CH] = 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: adc_sequencing_control_tb.sv */
`default_nettype none
module adc_sequencing_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i, rst_n_i, wr_i, rd_i, cmp_i, irq_o, sample_o, rd_seen;
    logic [3:0] addr_i;
    logic [7:0] wdata_i, rdata_o, port_a, port_b, port_e, analog_en_o;
    logic [7:0] lfsr_r, me, mm, an, cfg, cw;
    logic [3:0] vc;
    logic [2:0] ref_high_sel_o;
    logic [1:0] ref_low_sel_o;
    logic [7:0] exp_q[$];
    logic [7:0] mask_q[$];
    string name_q[$];
    int bad_count = 0;
    int tests_run = 0;
    int div;
    int dtab[4] = '{2, 8, 32, 64};
    logic [3:0] vtab[5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};

    asc_converter u_dut (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .port_a_pins_i(port_a), .port_b_pins_i(port_b),
        .port_e_pins_i(port_e), .cmp_i(cmp_i),
        .ref_high_sel_o(ref_high_sel_o), .ref_low_sel_o(ref_low_sel_o),
        .analog_en_o(analog_en_o), .sample_o(sample_o), .irq_o(irq_o)
    );

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic logic [7:0] ctl(input logic [1:0] sel,
        input logic [2:0] ch, input logic go, input logic pwr);
        return {sel, ch, go, 1'b0, pwr};
    endfunction

    task automatic chk(input string n, input logic [7:0] e,
        input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge sys_clk_i) rd_seen <= rd_i;
    always @(negedge sys_clk_i) begin
        if (rd_seen === 1'b1 && exp_q.size() > 0) begin
            me = exp_q.pop_front();
            mm = mask_q.pop_front();
            chk(name_q.pop_front(), me & mm, rdata_o & mm);
        end
    end

    task automatic bus(input logic w, input logic r, input logic [3:0] a,
        input logic [7:0] d);
        @(posedge sys_clk_i);
        wr_i <= w;
        rd_i <= r;
        addr_i <= a;
        wdata_i <= d;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask

    task automatic rd_exp(input string n, input logic [3:0] a,
        input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back(e);
        mask_q.push_back(m);
        name_q.push_back(n);
        bus(1'b0, 1'b1, a, 8'h00);
    endtask

    // ends on a falling edge so direct checks see settled outputs
    task automatic idle(input int n);
        repeat (n) bus(1'b0, 1'b0, 4'h0, 8'h00);
        @(negedge sys_clk_i);
    endtask

    initial begin
        repeat (30000) @(posedge sys_clk_i);
        bad_count++;
        $display("watchdog expired");
        summarize();
    end

    initial begin
        rst_n_i = 1'b0;
        {wr_i, rd_i} = 2'b00;
        addr_i = 4'h0;
        wdata_i = 8'h00;
        cmp_i = 1'b1;
        {port_a, port_b, port_e} = 24'h000000;
        lfsr_r = 8'h55;
        repeat (6) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        rd_exp("control", asc_pkg::ADDR_CONTROL, asc_pkg::CONTROL_RESET, 8'hff);
        rd_exp("pin_ref", asc_pkg::ADDR_PIN_REF_CONFIG, asc_pkg::PIN_REF_RESET,
            8'hff);
        rd_exp("direction", asc_pkg::ADDR_PIN_DIRECTION,
            asc_pkg::DIRECTION_RESET, 8'hff);
        rd_exp("unmapped", 4'hf, 8'h00, 8'hff);
        for (int i = 0; i < 9; i++) begin
            vc = vtab[i % 5];
            cfg = {vc, i[3:0]};
            lfsr_r = lfsr_next(lfsr_r);
            wr(asc_pkg::ADDR_PIN_REF_CONFIG, cfg);
            port_a <= lfsr_r;
            port_b <= ~lfsr_r;
            port_e <= {lfsr_r[3:0], lfsr_r[7:4]};
            idle(5);
            an = (i < 8 ? 8'hff >> i : 8'h00) | {4'h0, vc[0], vc[1], 2'b00};
            chk("analog_en", an, analog_en_o);
            chk("ref_high", vc[0] ? 8'h02 : vc[2] ? 8'h00 : vc[3] ? 8'h01 :
                8'h03, {5'h00, ref_high_sel_o});
            chk("ref_low", vc[1] ? 8'h01 : vc[2] ? 8'h00 : 8'h02,
                {6'h00, ref_low_sel_o});
            rd_exp("port_a", asc_pkg::ADDR_PORT_A, port_a & ~an, 8'hff);
            rd_exp("port_b", asc_pkg::ADDR_PORT_B, port_b | an, 8'hff);
            rd_exp("port_e", asc_pkg::ADDR_PORT_E, port_e & ~an, 8'hff);
        end
        // every pin driven as output, channel varies: conversion must still run
        wr(asc_pkg::ADDR_PIN_DIRECTION, 8'h00);
        wr(asc_pkg::ADDR_IRQ_CLEAR, 8'h01);
        wr(asc_pkg::ADDR_IRQ_ENABLE, 8'h01);
        rd_exp("irq_enable", asc_pkg::ADDR_IRQ_ENABLE, 8'h01, 8'h01);
        for (int s = 0; s < 4; s++) begin
            div = dtab[s];
            cw = ctl(s[1:0], 3'(2 * s + 1), 1'b0, 1'b1);
            wr(asc_pkg::ADDR_CONTROL, cw);
            idle(3 * div);
            wr(asc_pkg::ADDR_CONTROL, cw | 8'h04);
            // go reads set up to the edge that ends the thirteenth period
            idle(13 * div);
            chk("irq_busy", 8'h00, {7'h00, irq_o});
            rd_exp("busy", asc_pkg::ADDR_CONTROL, 8'h04, 8'h04);
            rd_exp("done", asc_pkg::ADDR_CONTROL, 8'h00, 8'h04);
            rd_exp("status", asc_pkg::ADDR_IRQ_STATUS, 8'h01, 8'h01);
            rd_exp("res_high", asc_pkg::ADDR_RESULT_HIGH, 8'h0f, 8'hff);
            rd_exp("res_low", asc_pkg::ADDR_RESULT_LOW, 8'hff, 8'hff);
            idle(2);
            chk("irq_done", 8'h01, {7'h00, irq_o});
            chk("sample_idle", 8'h00, {7'h00, sample_o});
            wr(asc_pkg::ADDR_IRQ_CLEAR, 8'h01);
            idle(2);
            chk("irq_cleared", 8'h00, {7'h00, irq_o});
        end
        wr(asc_pkg::ADDR_PIN_DIRECTION, 8'hff);
        // masked completion keeps the line low but still flags status
        wr(asc_pkg::ADDR_IRQ_ENABLE, 8'h00);
        wr(asc_pkg::ADDR_CONTROL, ctl(2'h0, 3'h0, 1'b1, 1'b1));
        idle(1);
        chk("sample_on", 8'h01, {7'h00, sample_o});
        idle(39);
        chk("irq_masked", 8'h00, {7'h00, irq_o});
        rd_exp("status_masked", asc_pkg::ADDR_IRQ_STATUS, 8'h01, 8'h01);
        wr(asc_pkg::ADDR_IRQ_ENABLE, 8'h01);
        idle(3);
        chk("irq_unmasked", 8'h01, {7'h00, irq_o});
        wr(asc_pkg::ADDR_RESULT_HIGH, 8'h55);
        rd_exp("res_high_ro", asc_pkg::ADDR_RESULT_HIGH, 8'h0f, 8'hff);
        // mid-run reset: results survive, control returns to reset value
        idle(2);
        @(posedge sys_clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        rd_exp("res_keep", asc_pkg::ADDR_RESULT_HIGH, 8'h0f, 8'hff);
        rd_exp("ctl_reset", asc_pkg::ADDR_CONTROL, asc_pkg::CONTROL_RESET,
            8'hff);
        // abort mid-way with the comparator low: high bits must drop
        cmp_i <= 1'b0;
        wr(asc_pkg::ADDR_IRQ_CLEAR, 8'h01);
        wr(asc_pkg::ADDR_CONTROL, ctl(2'h1, 3'h0, 1'b0, 1'b1));
        idle(24);
        wr(asc_pkg::ADDR_CONTROL, ctl(2'h1, 3'h0, 1'b1, 1'b1));
        idle(48);
        wr(asc_pkg::ADDR_CONTROL, ctl(2'h1, 3'h0, 1'b0, 1'b1));
        idle(2);
        rd_exp("abort_go", asc_pkg::ADDR_CONTROL, 8'h00, 8'h04);
        rd_exp("abort_high", asc_pkg::ADDR_RESULT_HIGH, 8'h00, 8'hff);
        rd_exp("abort_low", asc_pkg::ADDR_RESULT_LOW, 8'h00, 8'h0f);
        idle(200);
        rd_exp("abort_status", asc_pkg::ADDR_IRQ_STATUS, 8'h00, 8'h01);
        // power-on and start in one write: start is dropped
        wr(asc_pkg::ADDR_CONTROL, ctl(2'h0, 3'h0, 1'b0, 1'b0));
        wr(asc_pkg::ADDR_CONTROL, ctl(2'h0, 3'h5, 1'b1, 1'b1));
        idle(2);
        rd_exp("pwr_go", asc_pkg::ADDR_CONTROL, ctl(2'h0, 3'h5, 1'b0, 1'b1),
            8'hfd);
        idle(40);
        rd_exp("pwr_go_status", asc_pkg::ADDR_IRQ_STATUS, 8'h00, 8'h01);
        wr(asc_pkg::ADDR_CONTROL, ctl(2'h0, 3'h0, 1'b0, 1'b0));
        wr(asc_pkg::ADDR_CONTROL, ctl(2'h0, 3'h0, 1'b1, 1'b0));
        idle(2);
        rd_exp("off_go", asc_pkg::ADDR_CONTROL, 8'h00, 8'h05);
        idle(3);
        // full conversion with the comparator low resolves every bit to 0
        wr(asc_pkg::ADDR_CONTROL, ctl(2'h0, 3'h0, 1'b0, 1'b1));
        idle(6);
        wr(asc_pkg::ADDR_CONTROL, ctl(2'h0, 3'h0, 1'b1, 1'b1));
        idle(40);
        rd_exp("zero_high", asc_pkg::ADDR_RESULT_HIGH, 8'h00, 8'hff);
        rd_exp("zero_low", asc_pkg::ADDR_RESULT_LOW, 8'h00, 8'hff);
        idle(3);
        summarize();
    end
endmodule
`default_nettype wire
